// ==== hw/dpr_pkg.sv ====
// Constants shared by the dual-ported transfer memory
package dpr_pkg;
  // Memory size in bytes and derived word geometry
  localparam int unsigned MEM_BYTES = 2048;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORD_BYTES = 2;
  localparam int unsigned MEM_WORDS = MEM_BYTES / WORD_BYTES;
  localparam int unsigned WADDR_W = $clog2(MEM_WORDS);
  // Byte address width inside the memory window
  localparam int unsigned BADDR_W = WADDR_W + 1;
  // Data space width and window base at the top end of the data space
  localparam int unsigned SPACE_W = 16;
  localparam logic [SPACE_W-1:0] SPACE_TOP_BASE = 16'h8000 - 16'(MEM_BYTES);
  // Read data after reset
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  // Byte lane select bit position within a byte address
  localparam int unsigned LANE_BIT = 0;
endpackage

// ==== hw/dpr_mem.sv ====
// Two-port byte-lane memory array with registered read data
`timescale 1ns/1ps
module dpr_mem #(
  parameter int unsigned WORDS = 1024,
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Port A, the processor side, wins write collisions
  input wire logic a_en_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [1:0] a_we_i,
  input wire logic [DW-1:0] a_wdata_i,
  output logic [DW-1:0] a_rdata_o,
  // Port B, the transfer side
  input wire logic b_en_i,
  input wire logic [AW-1:0] b_addr_i,
  input wire logic [1:0] b_we_i,
  input wire logic [DW-1:0] b_wdata_i,
  output logic [DW-1:0] b_rdata_o
);
  logic [DW-1:0] mem_q [WORDS];
  logic [1:0] b_lane_ok;

  initial begin
    if (DW != 16 || WORDS > (2 ** AW) || WORDS == 0) begin
      $error("dpr_mem: unsupported geometry");
    end
  end

  // A lane written by both ports at once is taken from port A only
  assign b_lane_ok = (a_en_i && a_addr_i == b_addr_i) ? ~a_we_i : 2'b11;

  // Each lane has its own write line, the other lane is left alone
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 2; i++) begin
      if (b_en_i && b_we_i[i] && b_lane_ok[i]) begin
        mem_q[b_addr_i][i*8 +: 8] <= b_wdata_i[i*8 +: 8];
      end
      if (a_en_i && a_we_i[i]) begin
        mem_q[a_addr_i][i*8 +: 8] <= a_wdata_i[i*8 +: 8];
      end
    end
  end

  // Read before write: a port reading a word it writes sees the old value
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      a_rdata_o <= '0;
    end else if (a_en_i) begin
      a_rdata_o <= mem_q[a_addr_i];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      b_rdata_o <= '0;
    end else if (b_en_i) begin
      b_rdata_o <= mem_q[b_addr_i];
    end
  end
endmodule

// ==== hw/dpr_ram.sv ====
// Dual-ported transfer memory shared by the processor and the transfer engine
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Holds 2 Kbytes of two-port memory at the top of the data space.
// - Both ports access any location in the same cycle, independently.
// - Transfer engine accesses never stall the processor nor take its cycles.
// - Same-location writes in one cycle keep the processor's data.
// - Byte writes update only the lane picked by address bit zero.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module dpr_ram #(
  parameter int unsigned MEM_BYTES = dpr_pkg::MEM_BYTES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Processor port, full data space byte address
  input wire logic cpu_en_i,
  input wire logic cpu_we_i,
  input wire logic cpu_byte_i,
  input wire logic [dpr_pkg::SPACE_W-1:0] cpu_addr_i,
  input wire logic [dpr_pkg::DATA_W-1:0] cpu_wdata_i,
  output logic [dpr_pkg::DATA_W-1:0] cpu_rdata_o,
  output logic cpu_hit_o,
  output logic cpu_ready_o,
  // Transfer engine port, byte address inside the memory
  input wire logic dma_en_i,
  input wire logic dma_we_i,
  input wire logic dma_byte_i,
  input wire logic [dpr_pkg::BADDR_W-1:0] dma_addr_i,
  input wire logic [dpr_pkg::DATA_W-1:0] dma_wdata_i,
  output logic [dpr_pkg::DATA_W-1:0] dma_rdata_o,
  output logic dma_ready_o
);
  localparam int unsigned WORDS = MEM_BYTES / dpr_pkg::WORD_BYTES;
  localparam int unsigned LB = dpr_pkg::LANE_BIT;

  initial begin
    if (MEM_BYTES != dpr_pkg::MEM_BYTES) begin
      $error("dpr_ram: memory size must match the data space window");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Processor decode: only the top window of the data space is ours
  logic cpu_sel;
  logic [dpr_pkg::SPACE_W-1:0] cpu_off;
  logic [1:0] cpu_we;
  logic [1:0] dma_we;
  logic [dpr_pkg::DATA_W-1:0] cpu_wd;
  logic [dpr_pkg::DATA_W-1:0] dma_wd;
  logic [dpr_pkg::DATA_W-1:0] cpu_raw;
  logic [dpr_pkg::DATA_W-1:0] dma_raw;
  logic cpu_lane_q;
  logic dma_lane_q;
  logic cpu_byte_q;
  logic dma_byte_q;
  logic cpu_hit_q;

  assign cpu_off = cpu_addr_i - dpr_pkg::SPACE_TOP_BASE;
  assign cpu_sel = cpu_en_i && cpu_addr_i >= dpr_pkg::SPACE_TOP_BASE
    && cpu_addr_i < 16'h8000;

  // Lane enables and lane steering of byte data
  function automatic logic [1:0] lanes(input logic we, input logic bw, input logic lane);
    logic [1:0] r;
    r = 2'b00;
    if (we) begin
      r = bw ? (lane ? 2'b10 : 2'b01) : 2'b11;
    end
    return r;
  endfunction

  assign cpu_we = lanes(cpu_we_i, cpu_byte_i, cpu_addr_i[LB]);
  assign dma_we = lanes(dma_we_i, dma_byte_i, dma_addr_i[LB]);
  assign cpu_wd = cpu_byte_i ? {2{cpu_wdata_i[7:0]}} : cpu_wdata_i;
  assign dma_wd = dma_byte_i ? {2{dma_wdata_i[7:0]}} : dma_wdata_i;

  // Neither port ever waits: there is no arbitration stall
  assign cpu_ready_o = 1'b1;
  assign dma_ready_o = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  dpr_mem #(
    .WORDS(WORDS),
    .AW(dpr_pkg::WADDR_W),
    .DW(dpr_pkg::DATA_W)
  ) u_mem (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .a_en_i(cpu_sel),
    .a_addr_i(cpu_off[dpr_pkg::BADDR_W-1:1]),
    .a_we_i(cpu_we),
    .a_wdata_i(cpu_wd),
    .a_rdata_o(cpu_raw),
    .b_en_i(dma_en_i),
    .b_addr_i(dma_addr_i[dpr_pkg::BADDR_W-1:1]),
    .b_we_i(dma_we),
    .b_wdata_i(dma_wd),
    .b_rdata_o(dma_raw)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Byte select for the read path, held beside the registered word
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cpu_lane_q <= 1'b0;
      cpu_byte_q <= 1'b0;
      cpu_hit_q <= 1'b0;
    end else begin
      cpu_hit_q <= cpu_sel;
      if (cpu_sel) begin
        cpu_lane_q <= cpu_addr_i[LB];
        cpu_byte_q <= cpu_byte_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dma_lane_q <= 1'b0;
      dma_byte_q <= 1'b0;
    end else if (dma_en_i) begin
      dma_lane_q <= dma_addr_i[LB];
      dma_byte_q <= dma_byte_i;
    end
  end

  // Byte reads land in the low byte, high byte zero
  assign cpu_rdata_o = !cpu_byte_q ? cpu_raw :
    {8'h00, cpu_lane_q ? cpu_raw[15:8] : cpu_raw[7:0]};
  assign dma_rdata_o = !dma_byte_q ? dma_raw :
    {8'h00, dma_lane_q ? dma_raw[15:8] : dma_raw[7:0]};
  assign cpu_hit_o = cpu_hit_q;
endmodule

// ==== bench/dpr_ram_sva.sv ====
// Port checks for the dual-ported transfer memory
`timescale 1ns/1ps
module dpr_ram_sva (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic cpu_en_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_rdata_o,
  input wire logic cpu_hit_o,
  input wire logic cpu_ready_o,
  input wire logic dma_en_i,
  input wire logic [15:0] dma_rdata_o,
  input wire logic dma_ready_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic win;
  assign win = cpu_addr_i[15:11] == 5'h0f;
  cpu_no_stall_a: assert property (cpu_ready_o) else $error("cpu stalled");
  dma_no_stall_a: assert property (dma_ready_o) else $error("dma stalled");
  window_hit_a: assert property (cpu_hit_o == $past(cpu_en_i && win))
    else $error("bad hit");
  cpu_hold_a: assert property (!$past(cpu_en_i && win) |-> $stable(cpu_rdata_o))
    else $error("cpu data moved");
  dma_hold_a: assert property (!$past(dma_en_i) |-> $stable(dma_rdata_o))
    else $error("dma data moved");
endmodule
bind dpr_ram dpr_ram_sva chk (.clock_i, .rst_i, .cpu_en_i, .cpu_addr_i, .cpu_rdata_o,
  .cpu_hit_o, .cpu_ready_o, .dma_en_i, .dma_rdata_o, .dma_ready_o);

// ==== bench/dpr_dma_model.sv ====
// Transfer engine model on the second port
`timescale 1ns/1ps
module dpr_dma_model (
  // Memory port
  output logic en_o,
  output logic we_o,
  output logic byte_o,
  output logic [10:0] addr_o,
  output logic [15:0] wdata_o
);
  initial {en_o, we_o, byte_o, addr_o, wdata_o} = '0;
  task automatic req(input logic w, b, input logic [10:0] a, input logic [15:0] d);
    {en_o, we_o, byte_o, addr_o, wdata_o} <= {1'b1, w, b, a, d};
  endtask
  // Released data toggles so a stale word never looks valid
  task automatic idle();
    {en_o, wdata_o} <= {1'b0, ~wdata_o};
  endtask
endmodule

// ==== bench/dpr_ram_tb_top.sv ====
// Self-checking bench for the dual-ported transfer memory
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module dpr_ram_tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic c_en = 1'b0;
  logic [1:0] c_m = 2'h0;
  logic [15:0] c_ad = 16'h0000, c_wd = 16'h0000;
  logic [15:0] c_rd, d_rd, d_wd;
  logic [10:0] d_ad;
  logic c_hit, d_en, d_we, d_by;
  int n_fail = 0, num_checks = 0;
  always #20 clock_i = ~clock_i;
  dpr_ram dut (.clock_i, .rst_i, .cpu_en_i(c_en), .cpu_we_i(c_m[1]), .cpu_byte_i(c_m[0]),
    .cpu_addr_i(c_ad), .cpu_wdata_i(c_wd), .cpu_rdata_o(c_rd), .cpu_hit_o(c_hit),
    .cpu_ready_o(), .dma_en_i(d_en), .dma_we_i(d_we), .dma_byte_i(d_by),
    .dma_addr_i(d_ad), .dma_wdata_i(d_wd), .dma_rdata_o(d_rd), .dma_ready_o());
  dpr_dma_model dma (.en_o(d_en), .we_o(d_we), .byte_o(d_by), .addr_o(d_ad), .wdata_o(d_wd));
  ////////////////////////////////////////
  // Mode bits are cpu write, cpu byte, dma write, dma byte
  task automatic ac(input logic [3:0] m, input logic [15:0] ca, cd, input logic [10:0] da,
    input logic [15:0] dd);
    @(posedge clock_i);
    {c_en, c_m, c_ad, c_wd} <= {1'b1, m[3:2], ca, cd};
    dma.req(m[1], m[0], da, dd);
    @(posedge clock_i);
    {c_en, c_wd} <= {1'b0, ~c_wd};
    dma.idle();
    #1;
  endtask
  task automatic t_clash();
    ac(4'ha, 16'h7810, 16'haaaa, 11'h010, 16'h5555);
    ac(4'he, 16'h7812, 16'h00c3, 11'h012, 16'h9696);
    ac(4'h0, 16'h7810, 16'h0000, 11'h012, 16'h0000);
    `CHK("word", 16'haaaa, c_rd)
    `CHK("lane", 16'h96c3, d_rd)
  endtask
  task automatic t_lane();
    ac(4'ha, 16'h7820, 16'hbeef, 11'h022, 16'hcafe);
    ac(4'hf, 16'h7823, 16'h0011, 11'h020, 16'h0044);
    ac(4'h0, 16'h7822, 16'h0000, 11'h020, 16'h0000);
    `CHK("odd", 16'h11fe, c_rd)
    `CHK("even", 16'hbe44, d_rd)
    ac(4'h5, 16'h7821, 16'h0000, 11'h023, 16'h0000);
    `CHK("cbyte", 16'h00be, c_rd)
    `CHK("dbyte", 16'h0011, d_rd)
  endtask
  task automatic t_win();
    ac(4'h8, 16'h7ffe, 16'h1278, 11'h000, 16'h0000);
    ac(4'h7, 16'h7fff, 16'h0000, 11'h7ff, 16'h00a5);
    `CHK("old", 16'h0012, c_rd)
    ac(4'h4, 16'h7fff, 16'h0000, 11'h7fe, 16'h0000);
    `CHK("top", 16'h00a5, c_rd)
    `CHK("dtop", 16'ha578, d_rd)
    `CHK("hit", 1'b1, c_hit)
    ac(4'h8, 16'h77fe, 16'hdead, 11'h7fe, 16'h0000);
    `CHK("low", 1'b0, c_hit)
    ac(4'h0, 16'h8000, 16'h0000, 11'h7fe, 16'h0000);
    `CHK("high", 1'b0, c_hit)
    `CHK("held", 16'h00a5, c_rd)
    `CHK("alias", 16'ha578, d_rd)
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    t_clash();
    t_lane();
    t_win();
    give_verdict();
  end
  // About forty cycles are needed; allow a wide margin
  initial begin
    #20us;
    n_fail++;
    give_verdict();
  end
endmodule
